// [hw/modbus_defines.vh]
// Constants shared by the serial-link command handler and its check unit.
// Assumes inclusion by bare name from files under hw/.
`ifndef MODBUS_DEFINES_VH
`define MODBUS_DEFINES_VH

// Function codes served, and the exception flag added to them
`define MB_FN_COIL_RD 8'h01
`define MB_FN_HREG_RD 8'h03
`define MB_FN_COIL_WR 8'h05
`define MB_FN_EXC_FLAG 8'h80

// Exception codes
`define MB_EXC_FUNC 8'h01
`define MB_EXC_ADDR 8'h02
`define MB_EXC_DATA 8'h03
`define MB_EXC_DENIED 8'h22

// Single coil write data values
`define MB_COIL_ON 16'hFF00
`define MB_COIL_OFF 16'h0000

// Coil space, read limits and the serial run source setting
`define MB_NUM_COILS 17'h00020
`define MB_COIL_MAX_CNT 16'h07D0
`define MB_HREG_MAX_CNT 16'h0010
`define MB_HREG_SPACE 17'h10000
`define MB_RUN_SRC_SERIAL 8'h03
`define MB_RUN_COIL_ADDR 16'h0000

// Query layout: every served query is eight bytes long
`define MB_QUERY_LEN 4'h8
`define MB_MIN_FRAME 4'h4

// Check value: reflected form of x^16 + x^15 + x^2 + 1
`define MB_CRC_POLY 16'hA001
`define MB_CRC_INIT 16'hFFFF

`endif

// [hw/crc16_byte_unit.v]
// Running 16-bit frame check over a byte stream, one byte per clock.
// Assumes bytes are fed only while feed is high; clear wins over feed.
`timescale 1ns/1ps
`default_nettype none
`include "modbus_defines.vh"

module crc16_byte_unit (
  input wire mclk, // System clock
  input wire rst_n, // Synchronous reset, active low
  input wire clear, // Restart the check value
  input wire feed, // Fold data into the check value
  input wire [7:0] data, // Byte to fold in
  output reg [15:0] crc_reg // Current check value, low byte sent first
);

  reg [15:0] crc_next;
  reg [15:0] work;
  integer i;

  // Eight shift steps of the reflected polynomial
  always @* begin
    work = crc_reg ^ {8'h00, data};
    for (i = 0; i < 8; i = i + 1) begin
      if (work[0]) begin
        work = (work >> 1) ^ `MB_CRC_POLY;
      end else begin
        work = work >> 1;
      end
    end
    crc_next = work;
  end

  // Check value register
  always @(posedge mclk) begin
    if (!rst_n || clear) begin
      crc_reg <= `MB_CRC_INIT;
    end else if (feed) begin
      crc_reg <= crc_next;
    end
  end

endmodule
`default_nettype wire

// [hw/modbus_rtu_coil_register_handler.v]
// Slave-side interpreter for coil read, holding register read and single
// coil write queries arriving as bytes on a serial link.
// Assumes an outside receiver delivers bytes and marks the frame end, and an
// outside transmitter takes response bytes by a valid/ready handshake.
//
// Notes on behaviour
// - Coil read query: address, 01h, start and count high byte first, CRC.
// - Coil address in a query equals coil number minus one.
// - In a coil data byte the lowest coil sits in bit0, upward to bit7.
// - First coil data byte sent holds the lowest coil addresses.
// - Coil positions beyond the defined coil range are reported as zero.
// - Broadcast coil and register reads are not served.
// - Register read 03h returns count consecutive registers from start.
// - Register response: address, function, 2 per register, data MSB first.
// - Register address in a query equals register number minus one.
// - Coil write 05h: FF00h turns coil on, 0000h turns it off.
// - Run coil 0001 acts only when run source selection equals 03.
// - Frames end in a 16-bit check; mismatching queries are discarded.
// - Invalid content: no action, reply function plus 80h and a code.
// - Queries for another slave address are ignored without reply.
`timescale 1ns/1ps
`default_nettype none
`include "modbus_defines.vh"

module modbus_rtu_coil_register_handler (
  input wire mclk, // System clock, 125 MHz
  input wire rst_n, // Synchronous reset, active low
  input wire [7:0] own_addr, // Configured slave address
  input wire [7:0] run_source_select, // Run command source setting
  input wire [7:0] rx_byte, // Received byte
  input wire rx_valid, // Received byte strobe
  input wire rx_frame_end, // Pulse: silent gap seen, frame complete
  input wire [31:0] coil_state, // Present coil states, bit n is address n
  input wire [15:0] reg_rdata, // Holding register content at reg_rd_addr
  input wire reg_exists, // Holding register at reg_rd_addr exists
  input wire tx_ready, // Transmitter takes tx_byte
  output reg [15:0] reg_rd_addr, // Holding register address being read
  output reg reg_rd_en, // Holding register read strobe
  output reg [7:0] tx_byte, // Response byte
  output reg tx_valid, // Response byte valid
  output reg busy, // Query under service, receive ignored
  output reg coil_wr_strobe, // Pulse: coil write accepted
  output reg [15:0] coil_wr_addr, // Written coil address
  output reg coil_wr_value, // Written coil state
  output reg run_cmd // Run request from the serial link
);

  localparam S_IDLE = 3'd0;
  localparam S_DECODE = 3'd1;
  localparam S_RADDR = 3'd2;
  localparam S_RCAP = 3'd3;
  localparam S_LOAD = 3'd4;
  localparam S_SEND = 3'd5;

  reg [2:0] state_reg;
  reg [7:0] q_reg [0:7];
  reg [15:0] hbuf_reg [0:15];
  reg [3:0] rx_cnt_reg;
  reg [7:0] idx_reg;
  reg [7:0] dlen_reg;
  reg exc_reg;
  reg [7:0] exc_code_reg;
  reg [3:0] ri_reg;
  reg [7:0] byte_sel;
  reg [3:0] rx_len_seen; // Query length caught as the frame closes
  wire [15:0] rx_crc;
  wire [15:0] tx_crc;
  wire [7:0] func;
  wire [15:0] start;
  wire [15:0] count;
  wire [15:0] wdata;
  wire [16:0] hreg_end;
  wire [15:0] coil_base;
  wire [7:0] coil_k;
  wire [7:0] coil_bits;
  wire [7:0] hsel;
  wire rx_take;
  wire tx_feed;
  wire frame_ok;

  // Bytes needed to hold a coil count, rounded up
  function [7:0] coil_bytes;
    input [15:0] cnt;
    reg [16:0] sum;
    begin
      sum = {1'b0, cnt} + 17'h00007;
      coil_bytes = sum[10:3];
    end
  endfunction

  // Query fields, all sent high byte first
  assign func = q_reg[1];
  assign start = {q_reg[2], q_reg[3]};
  assign count = {q_reg[4], q_reg[5]};
  assign wdata = {q_reg[4], q_reg[5]};
  assign hreg_end = {1'b0, start} + {1'b0, count};

  // Receive only while idle; the buffer keeps the first eight bytes
  assign rx_take = (state_reg == S_IDLE) && rx_valid;
  assign tx_feed = (state_reg == S_SEND) && tx_ready && (idx_reg < dlen_reg);
  // Residue zero means the trailing check value matched
  assign frame_ok = (rx_cnt_reg >= `MB_MIN_FRAME) && (rx_crc == 16'h0000)
    && (q_reg[0] == own_addr) && (q_reg[0] != 8'h00);

  // Check units for the query and the response
  crc16_byte_unit u_rx_crc (
    .mclk(mclk),
    .rst_n(rst_n),
    .clear((state_reg == S_IDLE) && rx_frame_end),
    .feed(rx_take),
    .data(rx_byte),
    .crc_reg(rx_crc)
  );

  crc16_byte_unit u_tx_crc (
    .mclk(mclk),
    .rst_n(rst_n),
    .clear(state_reg == S_DECODE),
    .feed(tx_feed),
    .data(tx_byte),
    .crc_reg(tx_crc)
  );

  // Query byte store
  always @(posedge mclk) begin
    if (rx_take && (rx_cnt_reg < `MB_QUERY_LEN)) begin
      q_reg[rx_cnt_reg[2:0]] <= rx_byte;
    end
  end

  // Coil data byte k covers coils start+8k .. start+8k+7
  assign coil_k = idx_reg - 8'h03;
  assign coil_base = {5'h00, coil_k, 3'h0};

  genvar j;
  generate
    for (j = 0; j < 8; j = j + 1) begin : g_coil
      localparam [2:0] JB = j;
      wire [15:0] offs;
      wire [16:0] absn;
      assign offs = {coil_base[15:3], JB};
      assign absn = {1'b0, start} + {1'b0, offs};
      assign coil_bits[j] = (offs < count) && (absn < `MB_NUM_COILS) ?
        coil_state[absn[4:0]] : 1'b0;
    end
  endgenerate

  // Register data byte: even index is the high byte
  assign hsel = idx_reg - 8'h03;

  // Response byte selection by position
  always @* begin
    byte_sel = 8'h00;
    if (idx_reg == 8'h00) begin
      byte_sel = q_reg[0];
    end else if (idx_reg == 8'h01) begin
      byte_sel = exc_reg ? (func | `MB_FN_EXC_FLAG) : func;
    end else if (exc_reg) begin
      byte_sel = exc_code_reg;
    end else if (func == `MB_FN_COIL_WR) begin
      byte_sel = q_reg[idx_reg[2:0]]; // Echo of the query
    end else if (func == `MB_FN_COIL_RD) begin
      byte_sel = (idx_reg == 8'h02) ? coil_bytes(count) : coil_bits;
    end else if (idx_reg == 8'h02) begin
      byte_sel = {count[6:0], 1'b0};
    end else if (hsel[0] == 1'b0) begin
      byte_sel = hbuf_reg[hsel[4:1]][15:8];
    end else begin
      byte_sel = hbuf_reg[hsel[4:1]][7:0];
    end
  end

  // Holding register capture during the read scan
  always @(posedge mclk) begin
    if ((state_reg == S_RCAP) && reg_exists) begin
      hbuf_reg[ri_reg] <= reg_rdata;
    end
  end

  // Main sequencer: receive, decode, read scan, send
  always @(posedge mclk) begin
    if (!rst_n) begin
      state_reg <= S_IDLE;
      rx_cnt_reg <= 4'h0;
      idx_reg <= 8'h00;
      dlen_reg <= 8'h00;
      exc_reg <= 1'b0;
      exc_code_reg <= 8'h00;
      ri_reg <= 4'h0;
      reg_rd_addr <= 16'h0000;
      reg_rd_en <= 1'b0;
      tx_byte <= 8'h00;
      tx_valid <= 1'b0;
      busy <= 1'b0;
      coil_wr_strobe <= 1'b0;
      coil_wr_addr <= 16'h0000;
      coil_wr_value <= 1'b0;
      run_cmd <= 1'b0;
    end else begin
      coil_wr_strobe <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          if (rx_frame_end) begin
            rx_cnt_reg <= 4'h0;
            if (frame_ok) begin
              state_reg <= S_DECODE;
              busy <= 1'b1;
            end
          end else if (rx_valid && (rx_cnt_reg != 4'hF)) begin
            rx_cnt_reg <= rx_cnt_reg + 4'h1;
          end
        end
        S_DECODE: begin
          idx_reg <= 8'h00;
          ri_reg <= 4'h0;
          exc_reg <= 1'b0;
          dlen_reg <= 8'h03;
          state_reg <= S_LOAD;
          if ((func != `MB_FN_COIL_RD) && (func != `MB_FN_HREG_RD) &&
              (func != `MB_FN_COIL_WR)) begin
            exc_reg <= 1'b1;
            exc_code_reg <= `MB_EXC_FUNC;
          end else if (q_len_bad(rx_len_seen)) begin
            state_reg <= S_IDLE;
            busy <= 1'b0;
          end else if (func == `MB_FN_COIL_RD) begin
            if ((count == 16'h0000) || (count > `MB_COIL_MAX_CNT)) begin
              exc_reg <= 1'b1;
              exc_code_reg <= `MB_EXC_DATA;
            end else if ({1'b0, start} >= `MB_NUM_COILS) begin
              exc_reg <= 1'b1;
              exc_code_reg <= `MB_EXC_ADDR;
            end else begin
              dlen_reg <= coil_bytes(count) + 8'h03;
            end
          end else if (func == `MB_FN_HREG_RD) begin
            if ((count == 16'h0000) || (count > `MB_HREG_MAX_CNT)) begin
              exc_reg <= 1'b1;
              exc_code_reg <= `MB_EXC_DATA;
            end else if (hreg_end > `MB_HREG_SPACE) begin
              exc_reg <= 1'b1;
              exc_code_reg <= `MB_EXC_ADDR;
            end else begin
              state_reg <= S_RADDR;
            end
          end else begin
            if ((wdata != `MB_COIL_ON) && (wdata != `MB_COIL_OFF)) begin
              exc_reg <= 1'b1;
              exc_code_reg <= `MB_EXC_DATA;
            end else if ({1'b0, start} >= `MB_NUM_COILS) begin
              exc_reg <= 1'b1;
              exc_code_reg <= `MB_EXC_ADDR;
            end else if ((start == `MB_RUN_COIL_ADDR) &&
                (run_source_select != `MB_RUN_SRC_SERIAL)) begin
              exc_reg <= 1'b1;
              exc_code_reg <= `MB_EXC_DENIED;
            end else begin
              dlen_reg <= 8'h06;
              coil_wr_strobe <= 1'b1;
              coil_wr_addr <= start;
              coil_wr_value <= (wdata == `MB_COIL_ON);
              if (start == `MB_RUN_COIL_ADDR) begin
                run_cmd <= (wdata == `MB_COIL_ON);
              end
            end
          end
        end
        S_RADDR: begin
          reg_rd_addr <= start + {12'h000, ri_reg};
          reg_rd_en <= 1'b1;
          state_reg <= S_RCAP;
        end
        S_RCAP: begin
          reg_rd_en <= 1'b0;
          if (!reg_exists) begin
            exc_reg <= 1'b1;
            exc_code_reg <= `MB_EXC_ADDR;
            state_reg <= S_LOAD;
          end else if ({12'h000, ri_reg} == count - 16'h0001) begin
            dlen_reg <= {count[6:0], 1'b0} + 8'h03;
            state_reg <= S_LOAD;
          end else begin
            ri_reg <= ri_reg + 4'h1;
            state_reg <= S_RADDR;
          end
        end
        S_LOAD: begin
          if (idx_reg < dlen_reg) begin
            tx_byte <= byte_sel;
          end else if (idx_reg == dlen_reg) begin
            tx_byte <= tx_crc[7:0];
          end else begin
            tx_byte <= tx_crc[15:8];
          end
          tx_valid <= 1'b1;
          state_reg <= S_SEND;
        end
        S_SEND: begin
          if (tx_ready) begin
            tx_valid <= 1'b0;
            if (idx_reg == dlen_reg + 8'h01) begin
              state_reg <= S_IDLE;
              busy <= 1'b0;
            end else begin
              idx_reg <= idx_reg + 8'h01;
              state_reg <= S_LOAD;
            end
          end
        end
        default: begin
          state_reg <= S_IDLE;
          busy <= 1'b0;
          tx_valid <= 1'b0;
          reg_rd_en <= 1'b0;
        end
      endcase
    end
  end

  // Length of the frame being decoded, caught as the frame closes
  always @(posedge mclk) begin
    if (!rst_n) begin
      rx_len_seen <= 4'h0;
    end else if ((state_reg == S_IDLE) && rx_frame_end) begin
      rx_len_seen <= rx_cnt_reg;
    end
  end

  // A served query has exactly eight bytes
  function q_len_bad;
    input [3:0] len;
    begin
      q_len_bad = (len != `MB_QUERY_LEN);
    end
  endfunction

endmodule
`default_nettype wire

// [dv/handler_checker_asserts.sv]
// Checker for the command handler: response handshake, read scan, writes.
// Assumes it is bound to the handler top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module handler_checker (
  input wire logic mclk, // Clock
  input wire logic rst_n, // Reset, active low
  input wire logic [7:0] own_addr, // Slave address
  input wire logic [7:0] run_source_select, // Run source setting
  input wire logic tx_ready, // Response taken
  input wire logic [15:0] reg_rd_addr, // Register read address
  input wire logic reg_rd_en, // Register read strobe
  input wire logic [7:0] tx_byte, // Response byte
  input wire logic tx_valid, // Response valid
  input wire logic busy, // Query in service
  input wire logic coil_wr_strobe, // Coil write pulse
  input wire logic [15:0] coil_wr_addr, // Written coil address
  input wire logic coil_wr_value, // Written coil state
  input wire logic run_cmd // Run request
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Handshake and framing of the response stream
  a_tx_hold: assert property (
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte))
    else $error("response byte dropped before taken");
  a_tx_gap: assert property (tx_valid && tx_ready |=> !tx_valid)
    else $error("response valid not lowered after take");
  a_tx_in_busy: assert property (tx_valid |-> busy)
    else $error("response byte outside a query");
  // A length-refused query raises busy for one cycle only, with no reply
  a_reply_addr: assert property ($rose(busy) ##2 busy |->
    ##[0:38] (tx_valid && tx_byte == own_addr))
    else $error("reply does not open with own address");
  // Register scan steps one address per read
  a_rd_pulse: assert property (reg_rd_en |=> !reg_rd_en)
    else $error("register read strobe longer than one cycle");
  a_rd_step: assert property (reg_rd_en && $past(reg_rd_en, 2) |->
    reg_rd_addr == $past(reg_rd_addr, 2) + 16'h0001)
    else $error("register scan not consecutive");
  // Coil writes and the run request
  a_wr_pulse: assert property (coil_wr_strobe |=> !coil_wr_strobe && busy)
    else $error("coil write pulse malformed");
  a_run_source: assert property (coil_wr_strobe &&
    coil_wr_addr == 16'h0000 |->
    run_source_select == 8'h03 && run_cmd == coil_wr_value)
    else $error("run coil written without serial run source");
  a_run_rise: assert property ($rose(run_cmd) |->
    coil_wr_strobe && coil_wr_value)
    else $error("run request rose without a coil write");
endmodule
bind modbus_rtu_coil_register_handler handler_checker chk (.mclk(mclk),
  .rst_n(rst_n), .own_addr(own_addr), .run_source_select(run_source_select),
  .tx_ready(tx_ready), .reg_rd_addr(reg_rd_addr), .reg_rd_en(reg_rd_en),
  .tx_byte(tx_byte), .tx_valid(tx_valid), .busy(busy),
  .coil_wr_strobe(coil_wr_strobe), .coil_wr_addr(coil_wr_addr),
  .coil_wr_value(coil_wr_value), .run_cmd(run_cmd));
`default_nettype wire

// [dv/serial_master_model.sv]
// Link master model: sends query frames with check value, takes replies.
// Assumes the bench waits for the reply and the silent gap between frames.
`timescale 1ns/1ps
`default_nettype none
module serial_master_model (
  input wire logic mclk, // Clock
  input wire logic [7:0] tx_byte, // Reply byte
  input wire logic tx_valid, // Reply valid
  output var logic tx_ready, // Reply taken
  output var logic [7:0] rx_byte, // Query byte
  output var logic rx_valid, // Query byte strobe
  output var logic rx_frame_end // Frame closed
);
  logic [7:0] got[$];
  logic slow = 1'b0;
  logic [1:0] ph = 2'h0;
  initial begin
    rx_byte = 8'h00;
    rx_valid = 1'b0;
    rx_frame_end = 1'b0;
  end
  // Takes reply bytes, stalling half the time when slow
  always @(posedge mclk) begin
    ph <= ph + 2'h1;
    tx_ready <= !slow || ph[1];
    if (tx_valid && tx_ready) got.push_back(tx_byte);
  end
  // Check value over a byte string, reflected polynomial
  function automatic logic [15:0] crc(input logic [7:0] b[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (b[i]) begin
      c = c ^ {8'h00, b[i]};
      repeat (8) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
    end
    return c;
  endfunction
  // Sends a frame, check low byte first, then marks its end
  task send(input logic [7:0] f[$], input bit bad);
    logic [15:0] c;
    c = crc(f) ^ {15'h0000, bad};
    f.push_back(c[7:0]);
    f.push_back(c[15:8]);
    foreach (f[i]) begin
      @(posedge mclk);
      rx_byte <= f[i];
      rx_valid <= 1'b1;
    end
    @(posedge mclk);
    rx_valid <= 1'b0;
    rx_byte <= ~c[15:8];
    rx_frame_end <= 1'b1;
    @(posedge mclk);
    rx_frame_end <= 1'b0;
  endtask
endmodule
`default_nettype wire

// [dv/test_modbus_rtu_coil_register_handler.sv]
// Bench for the command handler: reads, writes, exceptions, ignored frames.
// Assumes the master model on the link and a small register map here.
`timescale 1ns/1ps
`default_nettype none
module test_modbus_rtu_coil_register_handler;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] own_addr = 8'h01;
  logic [7:0] run_source_select = 8'h03;
  logic [31:0] coil_state = 32'h0000_0000;
  logic [15:0] reg_rdata, reg_rd_addr, coil_wr_addr;
  logic [7:0] rx_byte, tx_byte;
  logic reg_exists, rx_valid, rx_frame_end, tx_ready, tx_valid;
  logic reg_rd_en, busy, coil_wr_strobe, coil_wr_value, run_cmd;
  int errors = 0;
  int num_checks = 0;
  logic [7:0] rsp[$];
  always #4 mclk = ~mclk;
  // Register map: 64 registers, content derived from the address
  assign reg_rdata = {reg_rd_addr[7:0] ^ 8'hA5, reg_rd_addr[7:0]};
  assign reg_exists = reg_rd_addr < 16'h0040;
  modbus_rtu_coil_register_handler uut (.mclk(mclk), .rst_n(rst_n),
    .own_addr(own_addr), .run_source_select(run_source_select),
    .rx_byte(rx_byte), .rx_valid(rx_valid), .rx_frame_end(rx_frame_end),
    .coil_state(coil_state), .reg_rdata(reg_rdata), .reg_exists(reg_exists),
    .tx_ready(tx_ready), .reg_rd_addr(reg_rd_addr), .reg_rd_en(reg_rd_en),
    .tx_byte(tx_byte), .tx_valid(tx_valid), .busy(busy),
    .coil_wr_strobe(coil_wr_strobe), .coil_wr_addr(coil_wr_addr),
    .coil_wr_value(coil_wr_value), .run_cmd(run_cmd));
  serial_master_model m (.mclk(mclk), .tx_byte(tx_byte), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .rx_byte(rx_byte), .rx_valid(rx_valid),
    .rx_frame_end(rx_frame_end));
  task check(input string name, input logic [15:0] exp, got);
    num_checks++;
    if (exp !== got) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask
  task close_out;
    if (errors == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Sends six query bytes and compares the reply with rsp plus check value
  task run(input logic [47:0] f, input bit bad);
    logic [7:0] q[$];
    logic [15:0] c;
    q = {};
    for (int i = 5; i >= 0; i--) q.push_back(f[i*8 +: 8]);
    m.got.delete();
    m.send(q, bad);
    for (int i = 0; i < 300; i++) begin
      @(posedge mclk);
      #1;
      if (m.got.size() > 0 && !busy) break;
    end
    if (rsp.size() > 0) begin
      c = m.crc(rsp);
      rsp.push_back(c[7:0]);
      rsp.push_back(c[15:8]);
    end
    check("reply_length", 16'(rsp.size()), 16'(m.got.size()));
    for (int i = 0; i < rsp.size() && i < m.got.size(); i++)
      check("reply_byte", 16'(rsp[i]), 16'(m.got[i]));
    // Silent gap before the next query
    repeat (8) @(posedge mclk);
  endtask
  task t_coil_read;
    coil_state <= 32'h0000_1140;
    rsp = '{8'h01, 8'h01, 8'h01, 8'h45};
    run(48'h0101_0006_0007, 1'b0);
    coil_state <= 32'h0000_A5C3;
    m.slow = 1'b1;
    rsp = '{8'h01, 8'h01, 8'h02, 8'hC3, 8'hA5};
    run(48'h0101_0000_0010, 1'b0);
    m.slow = 1'b0;
    coil_state <= 32'hFFFF_FFFF;
    rsp = '{8'h01, 8'h01, 8'h02, 8'h0F, 8'h00};
    run(48'h0101_001C_0009, 1'b0);
    rsp = '{8'h01, 8'h81, 8'h03};
    run(48'h0101_0000_0000, 1'b0);
    rsp = '{8'h01, 8'h81, 8'h02};
    run(48'h0101_0020_0001, 1'b0);
  endtask
  task t_reg_read;
    rsp = '{8'h01, 8'h03, 8'h0C};
    for (int a = 17; a < 23; a++) begin
      rsp.push_back(8'(a) ^ 8'hA5);
      rsp.push_back(8'(a));
    end
    run(48'h0103_0011_0006, 1'b0);
    rsp = '{8'h01, 8'h83, 8'h02};
    run(48'h0103_003F_0002, 1'b0);
    rsp = '{8'h01, 8'h83, 8'h03};
    run(48'h0103_0000_0011, 1'b0);
  endtask
  task t_coil_write;
    rsp = '{8'h01, 8'h05, 8'h00, 8'h05, 8'hFF, 8'h00};
    run(48'h0105_0005_FF00, 1'b0);
    check("coil_wr_addr", 16'h0005, coil_wr_addr);
    check("coil_wr_value", 16'h0001, 16'(coil_wr_value));
    rsp = '{8'h01, 8'h85, 8'h03};
    run(48'h0105_0005_1234, 1'b0);
    check("coil_wr_value", 16'h0001, 16'(coil_wr_value));
    rsp = '{8'h01, 8'h05, 8'h00, 8'h00, 8'hFF, 8'h00};
    run(48'h0105_0000_FF00, 1'b0);
    check("run_cmd", 16'h0001, 16'(run_cmd));
    run_source_select <= 8'h00;
    rsp = '{8'h01, 8'h85, 8'h22};
    run(48'h0105_0000_0000, 1'b0);
    check("run_cmd", 16'h0001, 16'(run_cmd));
    run_source_select <= 8'h03;
    rsp = '{8'h01, 8'h05, 8'h00, 8'h00, 8'h00, 8'h00};
    run(48'h0105_0000_0000, 1'b0);
    check("run_cmd", 16'h0000, 16'(run_cmd));
  endtask
  task t_ignored;
    rsp = {};
    run(48'h0101_0000_0008, 1'b1);
    run(48'h0201_0000_0008, 1'b0);
    run(48'h0003_0000_0001, 1'b0);
    run(48'h0105_0003_FF00, 1'b1);
    check("coil_wr_addr", 16'h0000, coil_wr_addr);
    rsp = '{8'h01, 8'h84, 8'h01};
    run(48'h0104_0000_0001, 1'b0);
  endtask
  // Main sequence
  initial begin
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    t_coil_read();
    t_reg_read();
    t_coil_write();
    t_ignored();
    close_out();
  end
  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge mclk);
    errors++;
    close_out();
  end
endmodule
`default_nettype wire
